/* File: hdl/dspg_top.sv */
// Deep-sleep port clock gating block with AXI4-Lite register slave
// Notes on behaviour
// - Bits 7..0 clock ports H..A in deep-sleep
// - Access to gated port returns bus fault
// - Gating bits reset to zero
// - Enables picked from run, sleep, deep register
// - Sleep registers apply only with auto gating
`timescale 1ns/1ps
`default_nettype none
module dspg_top #(
  parameter int PORTS = 8 // Number of gated ports
) (
  input wire logic REF_CLK, // System clock 100 MHz
  input wire logic SRST, // Synchronous reset, active high
  input wire dspg_pkg::dspg_axi_req_s AXI_REQ, // AXI4-Lite requests
  output dspg_pkg::dspg_axi_rsp_s AXI_RSP, // AXI4-Lite answers
  input wire logic [1:0] POWER_MODE, // Mode from power controller
  input wire logic [PORTS-1:0] PORT_ACCESS_SEL, // One-hot port being accessed
  input wire logic PORT_ACCESS_STROBE, // Port access begins
  output logic PORT_BUS_FAULT, // Fault answer to port access
  output logic [PORTS-1:0] PORT_CLOCK_ENABLE, // Clock enables, A at bit 0
  output logic IRQ // Level interrupt
);
  import dspg_pkg::*;
  // ==========================================================
  // Registers
  logic [PORTS-1:0] run_port_clock_gate; // Run-mode gates
  logic [PORTS-1:0] sleep_port_clock_gate; // Sleep-mode gates
  logic [PORTS-1:0] deep_sleep_port_clock_gate; // Deep-sleep gates
  logic auto_clock_gating; // Auto gating bit of run config
  logic [NUM_IRQ-1:0] irq_status; // Sticky events
  logic [NUM_IRQ-1:0] irq_mask; // Interrupt mask
  logic [1:0] mode_q1; // Mode sync stage one
  logic [1:0] mode_q2; // Mode sync stage two
  logic [1:0] mode_last; // Previous synced mode
  logic [PORTS-1:0] sel_q1; // Select sync one
  logic [PORTS-1:0] sel_q2; // Select sync two
  logic stb_q1; // Strobe sync one
  logic stb_q2; // Strobe sync two
  logic fault; // Checker fault pulse
  // AXI state
  logic aw_have; // Address held
  logic w_have; // Data held
  logic [11:0] aw_addr; // Held write address
  logic [31:0] w_data; // Held write data
  logic [3:0] w_strb; // Held strobes
  logic bvalid; // Write answer pending
  logic [1:0] bresp; // Write answer code
  logic rvalid; // Read answer pending
  logic [1:0] rresp; // Read answer code
  logic [31:0] rdata; // Read data
  logic aw_ready, w_ready, ar_ready; // Registered readies
  // Next values
  logic next_aw_have, next_w_have, next_bvalid, next_rvalid;
  logic [11:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic [PORTS-1:0] next_run, next_sleep, next_deep, next_en;
  logic next_acg;
  logic [NUM_IRQ-1:0] next_status, next_mask, irq_event;
  logic [31:0] wr_val; // Strobed write value helper
  if (PORTS < 1 || PORTS > 8) begin : g_bad_ports
    $error("PORTS must be 1..8");
  end
  // ==========================================================
  // Input synchronisers for pins from other logic
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      mode_q1 <= DSPG_RUN;
      mode_q2 <= DSPG_RUN;
      mode_last <= DSPG_RUN;
      sel_q1 <= '0;
      sel_q2 <= '0;
      stb_q1 <= 1'b0;
      stb_q2 <= 1'b0;
    end else begin
      mode_q1 <= POWER_MODE;
      mode_q2 <= mode_q1;
      mode_last <= mode_q2;
      sel_q1 <= PORT_ACCESS_SEL;
      sel_q2 <= sel_q1;
      stb_q1 <= PORT_ACCESS_STROBE;
      stb_q2 <= stb_q1;
    end
  end
  // ==========================================================
  // Clock enable select per operating mode
  always_comb begin
    next_en = run_port_clock_gate;
    if (auto_clock_gating) begin
      if (mode_q2 == DSPG_DEEP) begin
        next_en = deep_sleep_port_clock_gate;
      end else if (mode_q2 == DSPG_SLEEP) begin
        next_en = sleep_port_clock_gate;
      end
    end
  end
  // Access checker
  dspg_port_check #(.PORTS(PORTS)) dspg_port_check_i (
    .REF_CLK(REF_CLK),
    .SRST(SRST),
    .port_sel(sel_q2),
    .port_strobe(stb_q2),
    .clk_en(PORT_CLOCK_ENABLE),
    .fault(fault)
  );
  // ==========================================================
  // AXI4-Lite slave next state
  always_comb begin
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_run = run_port_clock_gate;
    next_sleep = sleep_port_clock_gate;
    next_deep = deep_sleep_port_clock_gate;
    next_acg = auto_clock_gating;
    next_mask = irq_mask;
    next_status = irq_status;
    wr_val = '0;
    // Capture address and data, in either order
    if (!aw_have && AXI_REQ.awvalid) begin
      next_aw_have = 1'b1;
      next_aw_addr = AXI_REQ.awaddr;
    end
    if (!w_have && AXI_REQ.wvalid) begin
      next_w_have = 1'b1;
      next_w_data = AXI_REQ.wdata;
      next_w_strb = AXI_REQ.wstrb;
    end
    // Perform write once both held and no answer pending
    if (aw_have && w_have && !bvalid) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        wr_val[8*b +: 8] = w_strb[b] ? w_data[8*b +: 8] : 8'h00;
      end
      unique case ({aw_addr[11:2], 2'b00})
        RUN_CLOCK_CONFIG_OFS: begin
          if (w_strb[AUTO_CLOCK_GATING_BIT/8]) begin
            next_acg = wr_val[AUTO_CLOCK_GATING_BIT];
          end
        end
        RUN_PORT_CLOCK_GATE_OFS: begin
          if (w_strb[0]) next_run = wr_val[PORTS-1:0];
        end
        SLEEP_PORT_CLOCK_GATE_OFS: begin
          if (w_strb[0]) next_sleep = wr_val[PORTS-1:0];
        end
        DEEP_SLEEP_PORT_CLOCK_GATE_OFS: begin
          if (w_strb[0]) next_deep = wr_val[PORTS-1:0];
        end
        IRQ_STATUS_OFS: begin
          next_status = irq_status & ~wr_val[NUM_IRQ-1:0];
        end
        IRQ_MASK_OFS: begin
          if (w_strb[0]) next_mask = wr_val[NUM_IRQ-1:0];
        end
        POWER_MODE_OFS: begin
        end
        default: begin
          next_bresp = RESP_SLVERR;
        end
      endcase
    end
    if (bvalid && AXI_REQ.bready) begin
      next_bvalid = 1'b0;
    end
    // Read: accept when no answer pending
    if (!rvalid && AXI_REQ.arvalid) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      unique case ({AXI_REQ.araddr[11:2], 2'b00})
        RUN_CLOCK_CONFIG_OFS: next_rdata[AUTO_CLOCK_GATING_BIT] = auto_clock_gating;
        RUN_PORT_CLOCK_GATE_OFS: next_rdata[PORTS-1:0] = run_port_clock_gate;
        SLEEP_PORT_CLOCK_GATE_OFS: next_rdata[PORTS-1:0] = sleep_port_clock_gate;
        DEEP_SLEEP_PORT_CLOCK_GATE_OFS: next_rdata[PORTS-1:0] = deep_sleep_port_clock_gate;
        IRQ_STATUS_OFS: next_rdata[NUM_IRQ-1:0] = irq_status;
        IRQ_MASK_OFS: next_rdata[NUM_IRQ-1:0] = irq_mask;
        POWER_MODE_OFS: next_rdata[1:0] = mode_q2;
        default: next_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid && AXI_REQ.rready) begin
      next_rvalid = 1'b0;
    end
    // Events: set wins over write-one-clear
    irq_event = '0;
    irq_event[IRQ_FAULT_BIT] = fault;
    irq_event[IRQ_MODE_BIT] = (mode_q2 != mode_last);
    next_status = next_status | irq_event;
  end
  // Register everything
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
      aw_ready <= 1'b1;
      w_ready <= 1'b1;
      ar_ready <= 1'b1;
      run_port_clock_gate <= GATE_RESET[PORTS-1:0];
      sleep_port_clock_gate <= GATE_RESET[PORTS-1:0];
      deep_sleep_port_clock_gate <= GATE_RESET[PORTS-1:0];
      auto_clock_gating <= CONFIG_RESET[AUTO_CLOCK_GATING_BIT];
      irq_status <= '0;
      irq_mask <= '0;
      PORT_CLOCK_ENABLE <= '0;
      PORT_BUS_FAULT <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      aw_ready <= !next_aw_have;
      w_ready <= !next_w_have;
      ar_ready <= !next_rvalid;
      run_port_clock_gate <= next_run;
      sleep_port_clock_gate <= next_sleep;
      deep_sleep_port_clock_gate <= next_deep;
      auto_clock_gating <= next_acg;
      irq_status <= next_status;
      irq_mask <= next_mask;
      PORT_CLOCK_ENABLE <= next_en;
      PORT_BUS_FAULT <= fault;
      IRQ <= |(next_status & next_mask);
    end
  end
  // Bus outputs straight from flops
  always_comb begin
    AXI_RSP.awready = aw_ready;
    AXI_RSP.wready = w_ready;
    AXI_RSP.bvalid = bvalid;
    AXI_RSP.bresp = bresp;
    AXI_RSP.arready = ar_ready;
    AXI_RSP.rvalid = rvalid;
    AXI_RSP.rresp = rresp;
    AXI_RSP.rdata = rdata;
  end
  // ==========================================================
  // Assertions
  property p_deep_select;
    @(posedge REF_CLK) disable iff (SRST)
      (auto_clock_gating && mode_q2 == DSPG_DEEP) |=> (PORT_CLOCK_ENABLE == $past(deep_sleep_port_clock_gate));
  endproperty
  a_deep_select: assert property (p_deep_select) else $error("deep gates not applied");
  property p_fault_out;
    @(posedge REF_CLK) disable iff (SRST)
      (stb_q2 && |(sel_q2 & ~PORT_CLOCK_ENABLE)) |=> ##1 PORT_BUS_FAULT;
  endproperty
  a_fault_out: assert property (p_fault_out) else $error("no bus fault on gated port");
  property p_reset_zero;
    @(posedge REF_CLK) $past(SRST) |-> (deep_sleep_port_clock_gate == '0 && PORT_CLOCK_ENABLE == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("gates not zero after reset");
  property p_sleep_select;
    @(posedge REF_CLK) disable iff (SRST)
      (auto_clock_gating && mode_q2 == DSPG_SLEEP) |=> (PORT_CLOCK_ENABLE == $past(sleep_port_clock_gate));
  endproperty
  a_sleep_select: assert property (p_sleep_select) else $error("sleep gates not applied");
  property p_run_select;
    @(posedge REF_CLK) disable iff (SRST)
      (mode_q2 == DSPG_RUN) |=> (PORT_CLOCK_ENABLE == $past(run_port_clock_gate));
  endproperty
  a_run_select: assert property (p_run_select) else $error("run gates not applied");
  property p_no_acg;
    @(posedge REF_CLK) disable iff (SRST)
      !auto_clock_gating |=> (PORT_CLOCK_ENABLE == $past(run_port_clock_gate));
  endproperty
  a_no_acg: assert property (p_no_acg) else $error("sleep gates used without auto gating");
endmodule // dspg_top
`default_nettype wire

/* File: hdl/dspg_pkg.sv */
// Package for the deep-sleep port clock gating block: map, fields, types
package dspg_pkg;
  // Register byte offsets
  localparam logic [11:0] RUN_CLOCK_CONFIG_OFS = 12'h0_060;
  localparam logic [11:0] RUN_PORT_CLOCK_GATE_OFS = 12'h0_108;
  localparam logic [11:0] SLEEP_PORT_CLOCK_GATE_OFS = 12'h0_118;
  localparam logic [11:0] DEEP_SLEEP_PORT_CLOCK_GATE_OFS = 12'h0_128;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h0_200;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h0_204;
  localparam logic [11:0] POWER_MODE_OFS = 12'h0_208;
  // Field layout
  localparam int NUM_PORTS = 8;
  localparam int AUTO_CLOCK_GATING_BIT = 27;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] AUTO_CLOCK_GATING_MASK = 32'h0800_0000;
  // Interrupt status bits
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_MODE_BIT = 1;
  localparam int NUM_IRQ = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Power mode from the power-mode controller
  typedef enum logic [1:0] {
    DSPG_RUN = 2'b00,
    DSPG_SLEEP = 2'b01,
    DSPG_DEEP = 2'b11
  } dspg_mode_e;
  // AXI4-Lite request side from master
  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } dspg_axi_req_s;
  // AXI4-Lite answer side to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } dspg_axi_rsp_s;
endpackage

/* File: hdl/dspg_port_check.sv */
// Access checker: flags a port access whose clock is gated off
`timescale 1ns/1ps
`default_nettype none
module dspg_port_check #(
  parameter int PORTS = 8 // Number of port slots
) (
  input wire logic REF_CLK, // System clock
  input wire logic SRST, // Synchronous reset
  input wire logic [PORTS-1:0] port_sel, // One-hot port being accessed
  input wire logic port_strobe, // Access begins this cycle
  input wire logic [PORTS-1:0] clk_en, // Current port clock enables
  output logic fault // Registered fault pulse
);
  import dspg_pkg::*;
  logic next_fault; // Next fault value
  if (PORTS < 1 || PORTS > 32) begin : g_bad_ports
    $error("PORTS out of range");
  end
  // Fault when any selected port is unclocked
  always_comb begin
    next_fault = port_strobe && |(port_sel & ~clk_en);
  end
  // Register the fault
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      fault <= 1'b0;
    end else begin
      fault <= next_fault;
    end
  end
  property p_fault_follows;
    @(posedge REF_CLK) disable iff (SRST)
      (port_strobe && |(port_sel & ~clk_en)) |=> fault;
  endproperty
  a_fault_follows: assert property (p_fault_follows) else $error("gated access not faulted");
endmodule // dspg_port_check
`default_nettype wire

/* File: sim/dspg_far_model.sv */
// Far side model: power-mode controller and port modules
`timescale 1ns/1ps
`default_nettype none
module dspg_far_model (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic [1:0] mode_cmd, // Requested power mode
  input wire logic go, // Start one port access
  input wire logic [2:0] port, // Port index, 0 is A
  input wire logic fault, // Bus fault answer from block
  output logic [1:0] power_mode, // Mode pins into block
  output logic [7:0] sel, // One-hot port select
  output logic strobe, // Access strobe
  output logic [7:0] fault_cnt // Faults seen so far
);
  // ==========================================
  // Mode pins and port accesses
  // Select is scrambled between accesses so a stale value is never trusted
  // Drive pins and count fault answers
  always @(posedge clk) begin
    if (srst) begin
      power_mode <= 2'h0;
      sel <= 8'h00;
      strobe <= 1'b0;
      fault_cnt <= 8'h00;
    end else begin
      power_mode <= mode_cmd;
      strobe <= go;
      sel <= go ? (8'h01 << port) : ~sel;
      if (fault) begin // Fault answer for gated port
        fault_cnt <= fault_cnt + 8'h01;
      end
    end
  end
endmodule // dspg_far_model
`default_nettype wire

/* File: sim/deep_sleep_port_clock_gating_test.sv */
// Self-checking bench for the deep-sleep port clock gating block
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_port_clock_gating_test;
  import dspg_pkg::*;
  // ==========================================
  // Signals
  logic ref_clk; // Bench clock
  logic srst; // Bench reset
  dspg_axi_req_s req; // Bus requests
  dspg_axi_rsp_s rsp; // Bus answers
  logic [1:0] pmode; // Mode pins
  logic [7:0] psel; // Port select pins
  logic pstb; // Port strobe pin
  logic pfault; // Fault answer
  logic [7:0] pen; // Port clock enables
  logic irq; // Interrupt
  logic [1:0] mode_cmd; // Requested mode
  logic go; // Access request
  logic [2:0] port; // Access port
  logic [7:0] fault_cnt; // Faults counted
  int num_errors; // Mismatches
  int n_tests; // Comparisons
  int cyc; // Cycle counter
  logic [31:0] d; // Read data
  logic [1:0] r; // Response
  // ==========================================
  // Instances
  dspg_top #(.PORTS(8)) dspg_top_i (.REF_CLK(ref_clk), .SRST(srst), .AXI_REQ(req),
    .AXI_RSP(rsp), .POWER_MODE(pmode), .PORT_ACCESS_SEL(psel), .PORT_ACCESS_STROBE(pstb),
    .PORT_BUS_FAULT(pfault), .PORT_CLOCK_ENABLE(pen), .IRQ(irq));
  dspg_far_model dspg_far_model_i (.clk(ref_clk), .srst(srst), .mode_cmd(mode_cmd), .go(go),
    .port(port), .fault(pfault), .power_mode(pmode), .sel(psel), .strobe(pstb),
    .fault_cnt(fault_cnt));
  // ==========================================
  // Clock and timeout
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  // ==========================================
  // Tasks
  task automatic test_done();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    rs = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  // Bus read
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    v = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  // Change mode and let it cross the synchroniser
  task automatic set_mode(input logic [1:0] m);
    mode_cmd <= m;
    repeat (6) @(posedge ref_clk);
  endtask
  // One port access, then time for the fault answer
  task automatic access(input logic [2:0] p);
    @(posedge ref_clk);
    go <= 1'b1;
    port <= p;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    logic [1:0] modes [3];
    logic [7:0] exps [3];
    modes = '{DSPG_RUN, DSPG_SLEEP, DSPG_DEEP};
    exps = '{8'h11, 8'h22, 8'hA5};
    req = '0;
    srst = 1'b1;
    mode_cmd = DSPG_RUN;
    go = 1'b0;
    port = 3'h0;
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk("enables after reset", 32'h0000_0000, {24'h00_0000, pen});
    rd(DEEP_SLEEP_PORT_CLOCK_GATE_OFS, d, r);
    chk("deep gate reset", GATE_RESET, d);
    chk("deep gate resp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd(12'hFFC, d, r);
    chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped read data", 32'h0000_0000, d);
    wr(12'hFFC, 32'hFFFF_FFFF, r);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(RUN_PORT_CLOCK_GATE_OFS, 32'h0000_0011, r);
    wr(SLEEP_PORT_CLOCK_GATE_OFS, 32'h0000_0022, r);
    wr(DEEP_SLEEP_PORT_CLOCK_GATE_OFS, 32'hFFFF_FFA5, r);
    rd(DEEP_SLEEP_PORT_CLOCK_GATE_OFS, d, r);
    chk("deep gate readback", 32'h0000_00A5, d);
    set_mode(DSPG_DEEP);
    chk("deep without auto gating", 32'h0000_0011, {24'h00_0000, pen});
    set_mode(DSPG_SLEEP);
    chk("sleep without auto gating", 32'h0000_0011, {24'h00_0000, pen});
    wr(RUN_CLOCK_CONFIG_OFS, AUTO_CLOCK_GATING_MASK, r);
    for (int i = 0; i < 3; i++) begin
      set_mode(modes[i]);
      chk("enables per mode", {24'h00_0000, exps[i]}, {24'h00_0000, pen});
    end
    rd(POWER_MODE_OFS, d, r);
    chk("synced mode", {30'h0, DSPG_DEEP}, d);
    rd(IRQ_STATUS_OFS, d, r);
    chk("mode change event", 32'h0000_0002, d & 32'h0000_0002);
    wr(IRQ_MASK_OFS, 32'h0000_0001, r);
    rd(IRQ_MASK_OFS, d, r);
    chk("irq mask readback", 32'h0000_0001, d);
    wr(IRQ_STATUS_OFS, 32'h0000_0003, r);
    access(3'h1);
    chk("fault on gated port", 32'h0000_0001, {24'h00_0000, fault_cnt});
    chk("irq on fault", 32'h0000_0001, {31'h0, irq});
    access(3'h0);
    chk("no fault on clocked port", 32'h0000_0001, {24'h00_0000, fault_cnt});
    rd(IRQ_STATUS_OFS, d, r);
    chk("fault status", 32'h0000_0001, d & 32'h0000_0001);
    wr(IRQ_STATUS_OFS, 32'h0000_0003, r);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    access(3'h7);
    chk("no fault on port H", 32'h0000_0001, {24'h00_0000, fault_cnt});
    access(3'h6);
    chk("fault on port G", 32'h0000_0002, {24'h00_0000, fault_cnt});
    test_done();
  end
endmodule // deep_sleep_port_clock_gating_test
`default_nettype wire
